// ### src/ssr_dev.sv
// memory device end: instruction decoder, 16x16 ram and shadow array
// assumes the controller keeps the serial clock rate and select protocol
`timescale 1ns/1ps
module ssr_dev import ssr_pkg::*; #(
  parameter int STORE_CYCLES = SSR_STORE_CYC,
  parameter int RECALL_CYCLES = SSR_RECALL_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  ssr_if.dev bus,
  output logic standby_o,
  output logic sleep_o,
  output logic busy_o,
  output logic write_flag_o,
  output logic recalled_o
);
  localparam int TW = $clog2(STORE_CYCLES + 1);

  ssr_dev_state_t state;
  logic sel_q;
  logic sel_rise;
  logic sck_rise;
  logic sin_q;
  logic [3:0] addr;
  logic [2:0] op;
  logic [3:0] bp;
  logic [TW-1:0] tmr;
  logic tmr_done;
  logic busy;
  logic op_done;
  logic [2:0] next_op;
  ssr_dev_state_t cmd_state;
  logic wflag;
  logic recalled;
  logic sleeping;
  logic dout;
  logic [SSR_WIDTH-1:0] ram [SSR_WORDS];
  logic [SSR_WIDTH-1:0] nv [SSR_WORDS];

  function automatic ssr_dev_state_t ssr_dispatch(input logic [2:0] opc, input logic slp,
                                                  input logic wf, input logic rc);
    ssr_dev_state_t st;
    st = ST_HOLD;
    if (slp) begin
      if (opc == SSR_OP_RECALL) st = ST_RECALL;
    end else if (opc[2:1] == SSR_OP_READ_HI) begin
      st = ST_READ;
    end else if (opc == SSR_OP_WRITE) begin
      st = ST_WRITE;
    end else if (opc == SSR_OP_RECALL) begin
      st = ST_RECALL;
    end else if (opc == SSR_OP_STORE && wf && rc) begin
      st = ST_STORE;
    end
    return st;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ssr_sync u_sel (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(bus.sel),
    .q_o(sel_q),
    .rise_o(sel_rise),
    .fall_o()
  );
  ssr_sync u_sck (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(bus.serial_shift_clock),
    .q_o(),
    .rise_o(sck_rise),
    .fall_o()
  );
  ssr_sync u_sin (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(bus.serial_in_line),
    .q_o(sin_q),
    .rise_o(),
    .fall_o()
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode
  assign busy = (state == ST_STORE) || (state == ST_RECALL);
  assign next_op = {op[1:0], sin_q};
  assign op_done = sel_q && sck_rise && (state == ST_OP) && (bp == 4'h2);
  assign cmd_state = ssr_dispatch(next_op, sleeping, wflag, recalled);
  assign tmr_done = (state == ST_STORE) ? (tmr == TW'(STORE_CYCLES - 1))
                                        : (tmr == TW'(RECALL_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_STANDBY;
    end else if (busy) begin
      if (tmr_done) state <= sel_q ? ST_HOLD : ST_STANDBY;
    end else if (!sel_q) begin
      state <= ST_STANDBY;
    end else if (state == ST_STANDBY) begin
      state <= ST_HUNT;
    end else if (sck_rise) begin
      unique case (state)
        ST_HUNT: if (sin_q) state <= ST_ADDR;
        ST_ADDR: if (bp == 4'h3) state <= ST_OP;
        ST_OP: if (bp == 4'h2) state <= cmd_state;
        ST_READ, ST_WRITE, ST_HOLD, ST_STANDBY, ST_STORE, ST_RECALL: state <= state;
      endcase
    end
  end

  // instruction register and bit pointer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr <= 4'h0;
      op <= 3'h0;
      bp <= 4'h0;
    end else if (!sel_q || sel_rise) begin
      addr <= 4'h0;
      op <= 3'h0;
      bp <= 4'h0;
    end else if (sck_rise && !busy) begin
      unique case (state)
        ST_HUNT: bp <= 4'h0;
        ST_ADDR: begin
          addr <= {addr[2:0], sin_q};
          bp <= (bp == 4'h3) ? 4'h0 : bp + 4'h1;
        end
        ST_OP: begin
          op <= next_op;
          if (bp != 4'h2) begin
            bp <= bp + 4'h1;
          end else begin
            bp <= (cmd_state == ST_READ) ? 4'h1 : 4'h0;
          end
        end
        ST_READ, ST_WRITE: bp <= bp + 4'h1;
        ST_HOLD, ST_STANDBY, ST_STORE, ST_RECALL: bp <= bp;
      endcase
    end
  end

  // self-timed transfer counter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr <= '0;
    end else if (busy && !tmr_done) begin
      tmr <= tmr + TW'(1);
    end else begin
      tmr <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read output
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout <= 1'b0;
    end else if (op_done && cmd_state == ST_READ) begin
      dout <= ram[addr][0];
    end else if (sel_q && sck_rise && state == ST_READ) begin
      dout <= ram[addr][bp];
    end
  end
  assign bus.dout = dout;
  assign bus.dout_oe_n = (state != ST_READ);

  //////////////////////////////////////////////////////////////////////////////
  // arrays
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SSR_WORDS; i++) ram[i] <= SSR_WORD_RST;
    end else if (state == ST_RECALL && tmr_done) begin
      for (int i = 0; i < SSR_WORDS; i++) ram[i] <= nv[i];
    end else if (op_done && !sleeping && next_op == SSR_OP_SLEEP) begin
      for (int i = 0; i < SSR_WORDS; i++) ram[i] <= SSR_WORD_RST;
    end else if (sel_q && sck_rise && state == ST_WRITE && wflag) begin
      ram[addr][bp] <= sin_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SSR_WORDS; i++) nv[i] <= SSR_WORD_RST;
    end else if (state == ST_STORE && tmr_done) begin
      for (int i = 0; i < SSR_WORDS; i++) nv[i] <= ram[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wflag <= 1'b0;
    end else if (op_done && !sleeping && next_op == SSR_OP_WREN) begin
      wflag <= 1'b1;
    end else if (op_done && !sleeping && next_op == SSR_OP_WRDIS) begin
      wflag <= 1'b0;
    end else if (state == ST_STORE && tmr_done) begin
      wflag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recalled <= 1'b0;
    end else if (state == ST_RECALL && tmr_done) begin
      recalled <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleeping <= 1'b0;
    end else if (state == ST_RECALL && tmr_done) begin
      sleeping <= 1'b0;
    end else if (op_done && !sleeping && next_op == SSR_OP_SLEEP) begin
      sleeping <= 1'b1;
    end
  end

  assign standby_o = (state == ST_STANDBY);
  assign sleep_o = sleeping;
  assign busy_o = busy;
  assign write_flag_o = wflag;
  assign recalled_o = recalled;
endmodule

// ### src/ssr_pkg.sv
// constants, opcodes and states shared by both ends of the serial shadow ram link
// assumes a 40 MHz system clock on both ends
package ssr_pkg;
  localparam int SSR_WORDS = 16;
  localparam int SSR_WIDTH = 16;
  localparam int SSR_SYS_KHZ = 40000;
  localparam int SSR_SCK_MAX_KHZ = 900;
  localparam int SSR_SCK_PERIOD_CYC = (SSR_SYS_KHZ + SSR_SCK_MAX_KHZ - 1) / SSR_SCK_MAX_KHZ;
  localparam int SSR_SCK_HALF_CYC = (SSR_SCK_PERIOD_CYC + 1) / 2;
  localparam int SSR_STORE_MS = 10;
  localparam int SSR_STORE_CYC = SSR_SYS_KHZ * SSR_STORE_MS;
  localparam int SSR_RECALL_CYC = 16;
  localparam int SSR_INSTR_BITS = 8;
  localparam int SSR_XFER_BITS = SSR_INSTR_BITS + SSR_WIDTH;
  localparam logic [2:0] SSR_OP_WRITE = 3'h3;
  localparam logic [2:0] SSR_OP_RECALL = 3'h5;
  localparam logic [2:0] SSR_OP_STORE = 3'h1;
  localparam logic [2:0] SSR_OP_SLEEP = 3'h2;
  localparam logic [2:0] SSR_OP_WREN = 3'h4;
  localparam logic [2:0] SSR_OP_WRDIS = 3'h0;
  localparam logic [1:0] SSR_OP_READ_HI = 2'h3;
  localparam logic [1:0] SSR_REG_CMD = 2'h0;
  localparam logic [1:0] SSR_REG_WDATA = 2'h1;
  localparam logic [1:0] SSR_REG_RDATA = 2'h2;
  localparam logic [1:0] SSR_REG_STATUS = 2'h3;
  localparam int SSR_CMD_OP_LSB = 0;
  localparam int SSR_CMD_ADDR_LSB = 3;
  localparam int SSR_STAT_BUSY = 0;
  localparam int SSR_STAT_DONE = 1;
  localparam logic [15:0] SSR_WORD_RST = 16'h0000;
  typedef enum logic [3:0] {
    ST_STANDBY, ST_HUNT, ST_ADDR, ST_OP, ST_READ, ST_WRITE, ST_HOLD, ST_STORE, ST_RECALL
  } ssr_dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP} ssr_host_state_t;
endpackage

// ### src/ssr_if.sv
// serial lines between controller and memory device
// the shared data line is resolved here from the two enables, idle level high
`timescale 1ns/1ps
interface ssr_if;
  logic sel;
  logic serial_shift_clock;
  logic din;
  logic din_oe_n;
  logic dout;
  logic dout_oe_n;
  logic serial_in_line;
  assign serial_in_line = !din_oe_n ? din : (!dout_oe_n ? dout : 1'b1);
  modport dev (
    input sel,
    input serial_shift_clock,
    input serial_in_line,
    output dout,
    output dout_oe_n
  );
  modport host (
    output sel,
    output serial_shift_clock,
    output din,
    output din_oe_n,
    input serial_in_line
  );
endinterface

// ### src/ssr_sync.sv
// two flip-flop synchroniser with edge pulses on the synchronised level
// assumes d_i is asynchronous to clk_sys_i
`timescale 1ns/1ps
module ssr_sync (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic last;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= d_i;
      sync <= meta;
      last <= sync;
    end
  end
  assign q_o = sync;
  assign rise_o = sync && !last;
  assign fall_o = !sync && last;
endmodule

// ### src/ssr_host.sv
// controller end: register port in, serial instruction sequences out
// assumes the device end sits across ssr_if; serial clock made by a divider
`timescale 1ns/1ps
module ssr_host import ssr_pkg::*; #(
  parameter int HALF_CYCLES = SSR_SCK_HALF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  ssr_if.host bus,
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o
);
  localparam int DW = $clog2(HALF_CYCLES + 1);

  ssr_host_state_t state;
  logic [DW-1:0] div;
  logic tick;
  logic [SSR_XFER_BITS-1:0] tx;
  logic [4:0] idx;
  logic [4:0] last_idx;
  logic is_read;
  logic [15:0] wdata;
  logic [15:0] rx;
  logic done;
  logic sel;
  logic sck;
  logic oe_n;
  logic line_q;
  logic start;
  logic [2:0] cmd_op;
  logic [3:0] cmd_addr;

  assign cmd_op = wdata_i[SSR_CMD_OP_LSB +: 3];
  assign cmd_addr = wdata_i[SSR_CMD_ADDR_LSB +: 4];
  assign start = wr_i && addr_i == SSR_REG_CMD && state == H_IDLE;
  assign tick = (div == DW'(HALF_CYCLES - 1));

  ssr_sync u_line (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(bus.serial_in_line),
    .q_o(line_q),
    .rise_o(),
    .fall_o()
  );

  //////////////////////////////////////////////////////////////////////////////
  // serial clock divider, restarted with each phase
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= '0;
    end else if (state == H_IDLE || tick) begin
      div <= '0;
    end else begin
      div <= div + DW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= H_IDLE;
      sel <= 1'b0;
      sck <= 1'b0;
      oe_n <= 1'b1;
      tx <= '0;
      idx <= 5'h0;
      last_idx <= 5'h0;
      is_read <= 1'b0;
    end else begin
      unique case (state)
        H_IDLE: if (start) begin
          state <= H_SETUP;
          sel <= 1'b1;
          oe_n <= 1'b0;
          tx <= {1'b1, cmd_addr, cmd_op, {<<{wdata}}};
          idx <= 5'h0;
          is_read <= cmd_op[2:1] == SSR_OP_READ_HI;
          last_idx <= (cmd_op[2:1] == SSR_OP_READ_HI || cmd_op == SSR_OP_WRITE)
                      ? 5'(SSR_XFER_BITS - 1) : 5'(SSR_INSTR_BITS - 1);
        end
        H_SETUP: if (tick) state <= H_LOW;
        H_LOW: if (tick) begin
          state <= H_HIGH;
          sck <= 1'b1;
        end
        H_HIGH: if (tick) begin
          sck <= 1'b0;
          tx <= {tx[SSR_XFER_BITS-2:0], 1'b0};
          idx <= idx + 5'h1;
          if (is_read && idx == 5'(SSR_INSTR_BITS - 2)) oe_n <= 1'b1;
          if (idx == last_idx) begin
            state <= H_GAP;
            sel <= 1'b0;
            oe_n <= 1'b1;
          end else begin
            state <= H_LOW;
          end
        end
        H_GAP: if (tick) state <= H_IDLE;
      endcase
    end
  end

  // read data capture just before each rising serial clock
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx <= 16'h0000;
    end else if (state == H_LOW && tick && is_read && idx >= 5'(SSR_INSTR_BITS)) begin
      rx <= {line_q, rx[15:1]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdata <= 16'h0000;
    end else if (wr_i && addr_i == SSR_REG_WDATA) begin
      wdata <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done <= 1'b0;
    end else if (state == H_GAP && tick) begin
      done <= 1'b1;
    end else if (start) begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        SSR_REG_CMD: rdata_o <= 16'h0000;
        SSR_REG_WDATA: rdata_o <= wdata;
        SSR_REG_RDATA: rdata_o <= rx;
        SSR_REG_STATUS: rdata_o <= {14'h0000, done, state != H_IDLE};
      endcase
    end
  end

  assign bus.sel = sel;
  assign bus.serial_shift_clock = sck;
  assign bus.din = tx[SSR_XFER_BITS-1];
  assign bus.din_oe_n = oe_n;
endmodule

// ### testbench/ssr_checker.sv
// assertions on the serial link between controller and device ends
// assumes the host drives select, clock and data from the system clock
`timescale 1ns/1ps
module ssr_checker #(
  parameter int HALF_CYCLES = 23
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sel,
  input wire logic serial_shift_clock,
  input wire logic din,
  input wire logic din_oe_n,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic serial_in_line
);
  logic sck_q;
  logic [7:0] quiet;
  logic [4:0] rises;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since the serial clock last moved, saturating
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q <= 1'b0;
      quiet <= 8'hFF;
    end else begin
      sck_q <= serial_shift_clock;
      if (serial_shift_clock != sck_q) quiet <= 8'h00;
      else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
    end
  end
  // serial clock rises within the current frame
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rises <= 5'h00;
    else if (!sel) rises <= 5'h00;
    else if (serial_shift_clock && !sck_q && rises != 5'h1F) rises <= rises + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_marker_first: assert property ($rose(sel) |-> !din_oe_n && din)
    else $error("select rose without the marker bit driven");
  a_sck_half: assert property (serial_shift_clock != sck_q |-> quiet >= HALF_CYCLES - 1)
    else $error("serial clock phase shorter than the half period");
  a_clock_idle: assert property (!sel |-> !serial_shift_clock)
    else $error("serial clock high outside a frame");
  a_sel_gap: assert property ($fell(sel) |=> !sel [*3])
    else $error("select raised again too soon");
  a_bit_count: assert property ($fell(sel) |-> rises == 5'h08 || rises == 5'h18)
    else $error("frame length is neither 8 nor 24 clocks");
  a_no_contention: assert property (!(!din_oe_n && !dout_oe_n))
    else $error("both ends drive the shared line");
  a_dout_after_op: assert property (sel && !dout_oe_n |-> rises >= 5'h08)
    else $error("device drives before the instruction is complete");
  a_dout_release: assert property (!sel [*5] |-> dout_oe_n)
    else $error("device drives while deselected");
  a_dout_hold: assert property (quiet >= 8'h06 && !dout_oe_n && !$past(dout_oe_n)
    |-> $stable(dout))
    else $error("data out moved without a serial clock rise");
  c_read: cover property (sel && !dout_oe_n && !serial_in_line);
  c_long_frame: cover property ($fell(sel) && rises == 5'h18);
  c_short_frame: cover property ($fell(sel) && rises == 5'h08);
endmodule

// ### testbench/serial_shadow_ram_port_test.sv
// self-checking bench: controller and device ends joined over the link
// assumes one 40 MHz clock for both ends; software port driven here
`timescale 1ns/1ps
module serial_shadow_ram_port_test;
  import ssr_pkg::*;
  localparam int HALF = SSR_SCK_HALF_CYC;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic standby, asleep, busy, wflag, recalled;
  int mismatches = 0;
  int n_tests = 0;
  ssr_if link();
  always #12.5 clk_sys_i = ~clk_sys_i;
  ssr_dev #(.STORE_CYCLES(200), .RECALL_CYCLES(200)) i_ssr_dev (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .bus(link), .standby_o(standby), .sleep_o(asleep), .busy_o(busy),
    .write_flag_o(wflag), .recalled_o(recalled));
  ssr_host #(.HALF_CYCLES(HALF)) i_ssr_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .bus(link), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o));
  ssr_checker #(.HALF_CYCLES(HALF)) i_ssr_checker (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .sel(link.sel), .serial_shift_clock(link.serial_shift_clock),
    .din(link.din), .din_oe_n(link.din_oe_n), .dout(link.dout),
    .dout_oe_n(link.dout_oe_n), .serial_in_line(link.serial_in_line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // issue one instruction and poll until the host reports done
  task automatic run(input logic [2:0] op, input logic [3:0] a);
    logic [15:0] s;
    reg_wr(SSR_REG_CMD, {9'h000, a, op});
    for (int i = 0; i < 1000; i++) begin
      reg_rd(SSR_REG_STATUS, s);
      if (s[SSR_STAT_DONE] === 1'b1) break;
      if (i == 999) begin
        mismatches++;
        conclude();
      end
    end
  endtask
  task automatic wait_free();
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (busy === 1'b0) break;
      if (i == 299) begin
        mismatches++;
        conclude();
      end
    end
  endtask
  task automatic write_word(input logic [3:0] a, input logic [15:0] d);
    reg_wr(SSR_REG_WDATA, d);
    run(SSR_OP_WRITE, a);
  endtask
  task automatic read_word(input logic [3:0] a, input logic x, input logic [15:0] exp);
    logic [15:0] d;
    run({SSR_OP_READ_HI, x}, a);
    reg_rd(SSR_REG_RDATA, d);
    check(d, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] d;
    check({12'h000, standby, asleep, wflag, recalled}, 16'h0008);
    reg_rd(SSR_REG_CMD, d);
    check(d, 16'h0000);
  endtask
  task automatic t_store_early();
    run(SSR_OP_WREN, 4'h0);
    check({15'h0000, wflag}, 16'h0001);
    run(SSR_OP_STORE, 4'h0);
    check({14'h0000, busy, wflag}, 16'h0001);
  endtask
  task automatic t_recall();
    run(SSR_OP_RECALL, 4'h5);
    check({15'h0000, busy}, 16'h0001);
    wait_free();
    check({12'h000, standby, asleep, wflag, recalled}, 16'h000B);
    read_word(4'h5, 1'b0, 16'h0000);
  endtask
  task automatic t_write_locked();
    run(SSR_OP_WRDIS, 4'h0);
    check({15'h0000, wflag}, 16'h0000);
    write_word(4'h3, 16'h1234);
    read_word(4'h3, 1'b1, 16'h0000);
  endtask
  task automatic t_write_read();
    logic [15:0] d;
    run(SSR_OP_WREN, 4'h0);
    write_word(4'h3, 16'hA5C3);
    write_word(4'hC, 16'h5A3C);
    read_word(4'h3, 1'b1, 16'hA5C3);
    read_word(4'hC, 1'b0, 16'h5A3C);
    reg_wr(SSR_REG_RDATA, 16'hFFFF);
    reg_rd(SSR_REG_RDATA, d);
    check(d, 16'h5A3C);
    check({15'h0000, standby}, 16'h0001);
  endtask
  task automatic t_store();
    run(SSR_OP_STORE, 4'h0);
    check({15'h0000, busy}, 16'h0001);
    wait_free();
    check({15'h0000, wflag}, 16'h0000);
  endtask
  task automatic t_sleep();
    run(SSR_OP_SLEEP, 4'h0);
    check({15'h0000, asleep}, 16'h0001);
    read_word(4'h3, 1'b0, 16'hFFFF);
    run(SSR_OP_WREN, 4'h0);
    check({15'h0000, wflag}, 16'h0000);
    run(SSR_OP_RECALL, 4'h0);
    wait_free();
    check({15'h0000, asleep}, 16'h0000);
    read_word(4'h3, 1'b0, 16'hA5C3);
    read_word(4'hC, 1'b1, 16'h5A3C);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_store_early();
    t_recall();
    t_write_locked();
    t_write_read();
    t_store();
    t_sleep();
    conclude();
  end
endmodule
